// ---- core/cabe_execute.sv ----
// Purpose: Executes arithmetic, logic, skip, branch and indirect transfer operations.
// Assumes: The register file holds operands steady only at the cycle an operation is taken.
// Notes: One operation at a time; done marks the last cycle and the commit edge.
// Overview of operation
// (RULE1) Add with carry: destination gets destination plus source plus carry, ZCNVH, one cycle.
// (RULE2) Word add: register pair plus immediate, flags ZCNVS, two cycles.
// (RULE3) Word subtract: register pair minus immediate, flags ZCNVS, two cycles.
// (RULE4) Subtract constant: destination minus immediate, flags ZCNVH, one cycle.
// (RULE5) Subtract with carry registers: destination minus source minus carry, ZCNVH.
// (RULE6) Subtract with carry constant: destination minus immediate minus carry, ZCNVH.
// (RULE7) AND with constant into destination, flags ZNV only, one cycle.
// (RULE8) OR with constant into destination, flags ZNV only, one cycle.
// (RULE9) One's complement is all ones minus value; two's is zero minus value plus H.
// (RULE10) Clear bits: destination AND inverted mask, flags ZNV, one cycle.
// (RULE11) Set bits: mask ORed into destination, flags ZNV, one cycle.
// (RULE12) Test: register ANDed with itself, unchanged, flags ZNV, one cycle.
// (RULE13) Indirect jump loads PC from pointer pair, no flags, two cycles.
// (RULE14) Indirect call loads PC from pointer pair, no flags, three cycles.
// (RULE15) Compare-skip-equal advances PC by two or three when equal, no flags.
// (RULE16) Compare immediate computes destination minus constant, not stored, ZNVCH.
// (RULE17) Skip on register bit clear advances PC by two or three, no flags.
// (RULE18) Skip on I/O bit set advances PC by two or three, no flags.
// (RULE19) Branch on flag set adds offset plus one; one cycle, two when taken.
// (RULE20) Flags not affected by an operation keep their value.
`timescale 1ns/1ps
`default_nettype none
`include "cabe_map.svh"
module cabe_execute
    import cabe_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire cabe_op_t op_code,
    input wire logic [`CABE_DATA_W-1:0] rd_val,
    input wire logic [`CABE_DATA_W-1:0] rdh_val,
    input wire logic [`CABE_DATA_W-1:0] rr_val,
    input wire logic [`CABE_DATA_W-1:0] imm_val,
    input wire logic [`CABE_DATA_W-1:0] io_val,
    input wire logic [`CABE_BSEL_W-1:0] bit_sel,
    input wire logic [`CABE_REL_W-1:0] rel_off,
    input wire logic [`CABE_WORD_W-1:0] ptr_val,
    input wire logic next_two_word,
    output logic op_ready,
    output logic busy,
    output logic done,
    output logic wr_lo_en,
    output logic wr_hi_en,
    output logic [`CABE_DATA_W-1:0] res_lo_ff,
    output logic [`CABE_DATA_W-1:0] res_hi_ff,
    output logic [`CABE_DATA_W-1:0] status_ff,
    output logic [`CABE_WORD_W-1:0] pc_ff,
    output logic push_en,
    output logic [`CABE_WORD_W-1:0] push_addr_ff
);
    function automatic logic is_word_op(input cabe_op_t op);
        is_word_op = (op == CABE_OP_ADD_IMM_WORD) || (op == CABE_OP_SUB_IMM_WORD);
    endfunction : is_word_op

    cabe_state_t state_ff;
    cabe_op_t op_ff;
    logic [`CABE_CNT_W-1:0] cnt_ff;
    logic [`CABE_DATA_W-1:0] pend_status_ff;
    logic [`CABE_WORD_W-1:0] pend_pc_ff;
    logic wr_lo_pend_ff;
    logic wr_hi_pend_ff;
    logic push_pend_ff;
    logic take;
    logic cond;
    logic c_in;
    logic [`CABE_DATA_W-1:0] a8;
    logic [`CABE_DATA_W-1:0] b8;
    logic sub8;
    logic cin8;
    logic [`CABE_DATA_W-1:0] sum8;
    logic cout8;
    logic half8;
    logic ovf8;
    logic [`CABE_WORD_W-1:0] aw;
    logic [`CABE_WORD_W-1:0] bw;
    logic [`CABE_WORD_W-1:0] sumw;
    logic coutw;
    logic ovfw;
    logic [`CABE_DATA_W-1:0] nxt_res_lo;
    logic [`CABE_DATA_W-1:0] nxt_res_hi;
    logic [`CABE_DATA_W-1:0] nxt_status;
    logic [`CABE_WORD_W-1:0] nxt_pc;
    logic [`CABE_CNT_W-1:0] nxt_cnt;
    logic nxt_wr_lo;
    logic nxt_wr_hi;
    logic nxt_push;
    logic [`CABE_WORD_W-1:0] skip_step;
    logic s_flag;

    assign op_ready = (state_ff == CABE_ST_IDLE);
    assign busy = (state_ff != CABE_ST_IDLE);
    assign take = op_valid && op_ready;
    assign done = (state_ff == CABE_ST_EXEC) && (cnt_ff == `CABE_CYC_ONE);
    assign wr_lo_en = done && wr_lo_pend_ff;
    assign wr_hi_en = done && wr_hi_pend_ff;
    assign push_en = done && push_pend_ff;
    assign c_in = status_ff[`CABE_BIT_C];
    assign s_flag = status_ff[`CABE_BIT_S];
    assign aw = {rdh_val, rd_val};
    assign bw = {`CABE_ALL_ZERO, imm_val & `CABE_WIMM_MASK};
    assign skip_step = next_two_word ? `CABE_PC_THREE : `CABE_PC_TWO;

    // Operand steering for the byte-wide adder and subtractor.
    always_comb begin
        a8 = rd_val;
        b8 = rr_val;
        sub8 = 1'b1;
        cin8 = 1'b0;
        case (op_code)
            CABE_OP_ADD_CARRY: begin
                sub8 = 1'b0; // [RULE1]
                cin8 = c_in;
            end
            CABE_OP_SUB_CONST, CABE_OP_COMPARE_IMMEDIATE: b8 = imm_val; // [RULE4] [RULE16]
            CABE_OP_SUB_CARRY_REGS: cin8 = c_in; // [RULE5]
            CABE_OP_SUB_CARRY_CONST: begin
                b8 = imm_val; // [RULE6]
                cin8 = c_in;
            end
            CABE_OP_ONES_COMPLEMENT: begin
                a8 = `CABE_ALL_ONES; // [RULE9]
                b8 = rd_val;
            end
            CABE_OP_TWOS_COMPLEMENT: begin
                a8 = `CABE_ALL_ZERO; // [RULE9]
                b8 = rd_val;
            end
            default: begin
                b8 = rr_val;
            end
        endcase
    end

    cabe_addsub #(.W(`CABE_DATA_W)) u_alu8 (
        .a(a8),
        .b(b8),
        .cin(cin8),
        .sub(sub8),
        .sum(sum8),
        .cout(cout8),
        .half(half8),
        .ovf(ovf8)
    );

    cabe_addsub #(.W(`CABE_WORD_W)) u_aluw (
        .a(aw),
        .b(bw),
        .cin(1'b0),
        .sub(op_code == CABE_OP_SUB_IMM_WORD),
        .sum(sumw),
        .cout(coutw),
        .half(),
        .ovf(ovfw)
    );

    cabe_cond u_cond (
        .op_code(op_code),
        .rd_val(rd_val),
        .rr_val(rr_val),
        .io_val(io_val),
        .status(status_ff),
        .bit_sel(bit_sel),
        .cond(cond)
    );

    // Result, flags, next PC and cycle count for the offered operation.
    always_comb begin
        nxt_res_lo = sum8;
        nxt_res_hi = rdh_val;
        nxt_status = status_ff; // [RULE20]
        nxt_pc = pc_ff + `CABE_PC_ONE;
        nxt_cnt = `CABE_CYC_ONE;
        nxt_wr_lo = 1'b0;
        nxt_wr_hi = 1'b0;
        nxt_push = 1'b0;
        case (op_code)
            CABE_OP_ADD_CARRY, CABE_OP_SUB_CONST, CABE_OP_SUB_CARRY_REGS, CABE_OP_SUB_CARRY_CONST,
            CABE_OP_TWOS_COMPLEMENT, CABE_OP_COMPARE_IMMEDIATE: begin
                nxt_wr_lo = (op_code != CABE_OP_COMPARE_IMMEDIATE); // [RULE16]
                nxt_status[`CABE_BIT_Z] = (sum8 == `CABE_ALL_ZERO); // [RULE1] [RULE4] [RULE5] [RULE6]
                nxt_status[`CABE_BIT_C] = cout8;
                nxt_status[`CABE_BIT_N] = sum8[`CABE_DATA_W-1];
                nxt_status[`CABE_BIT_V] = ovf8;
                nxt_status[`CABE_BIT_H] = half8;
            end
            CABE_OP_ONES_COMPLEMENT: begin
                nxt_wr_lo = 1'b1;
                nxt_status[`CABE_BIT_Z] = (sum8 == `CABE_ALL_ZERO); // [RULE9]
                nxt_status[`CABE_BIT_C] = cout8;
                nxt_status[`CABE_BIT_N] = sum8[`CABE_DATA_W-1];
                nxt_status[`CABE_BIT_V] = ovf8;
            end
            CABE_OP_ADD_IMM_WORD, CABE_OP_SUB_IMM_WORD: begin
                nxt_res_lo = sumw[`CABE_DATA_W-1:0]; // [RULE2] [RULE3]
                nxt_res_hi = sumw[`CABE_WORD_W-1:`CABE_DATA_W];
                nxt_wr_lo = 1'b1;
                nxt_wr_hi = 1'b1;
                nxt_cnt = `CABE_CYC_TWO;
                nxt_status[`CABE_BIT_Z] = (sumw == {`CABE_ALL_ZERO, `CABE_ALL_ZERO});
                nxt_status[`CABE_BIT_C] = coutw;
                nxt_status[`CABE_BIT_N] = sumw[`CABE_WORD_W-1];
                nxt_status[`CABE_BIT_V] = ovfw;
                nxt_status[`CABE_BIT_S] = sumw[`CABE_WORD_W-1] ^ ovfw;
            end
            CABE_OP_AND_CONST, CABE_OP_OR_CONST, CABE_OP_CLEAR_BITS, CABE_OP_SET_BITS,
            CABE_OP_TEST_ZERO_MINUS: begin
                case (op_code)
                    CABE_OP_AND_CONST: nxt_res_lo = rd_val & imm_val; // [RULE7]
                    CABE_OP_CLEAR_BITS: nxt_res_lo = rd_val & (`CABE_ALL_ONES - imm_val); // [RULE10]
                    CABE_OP_TEST_ZERO_MINUS: nxt_res_lo = rd_val & rd_val; // [RULE12]
                    default: nxt_res_lo = rd_val | imm_val; // [RULE8] [RULE11]
                endcase
                nxt_wr_lo = 1'b1;
                nxt_status[`CABE_BIT_Z] = (nxt_res_lo == `CABE_ALL_ZERO);
                nxt_status[`CABE_BIT_N] = nxt_res_lo[`CABE_DATA_W-1];
                nxt_status[`CABE_BIT_V] = 1'b0;
            end
            CABE_OP_INDIRECT_JUMP: begin
                nxt_pc = ptr_val; // [RULE13]
                nxt_cnt = `CABE_CYC_TWO;
            end
            CABE_OP_INDIRECT_CALL: begin
                nxt_pc = ptr_val; // [RULE14]
                nxt_cnt = `CABE_CYC_THREE;
                nxt_push = 1'b1;
            end
            CABE_OP_COMPARE_SKIP_EQUAL, CABE_OP_SKIP_REG_BIT_CLEAR, CABE_OP_SKIP_IO_BIT_SET: begin
                if (cond) begin
                    nxt_pc = pc_ff + skip_step; // [RULE15] [RULE17] [RULE18]
                    nxt_cnt = next_two_word ? `CABE_CYC_THREE : `CABE_CYC_TWO;
                end
            end
            CABE_OP_BRANCH_FLAG_SET: begin
                if (cond) begin
                    nxt_pc = pc_ff + `CABE_WORD_W'($signed(rel_off)) + `CABE_PC_ONE; // [RULE19]
                    nxt_cnt = `CABE_CYC_TWO;
                end
            end
            default: begin
                nxt_res_lo = rd_val;
            end
        endcase
    end

    // Sequencer: counts the cycles of the taken operation down to done.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= CABE_ST_IDLE;
            cnt_ff <= `CABE_CYC_ONE;
        end else begin
            case (state_ff)
                CABE_ST_IDLE: begin
                    if (take) begin
                        state_ff <= CABE_ST_EXEC;
                        cnt_ff <= nxt_cnt;
                    end
                end
                CABE_ST_EXEC: begin
                    if (done) begin
                        state_ff <= CABE_ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - `CABE_CYC_ONE;
                    end
                end
                default: begin
                    state_ff <= CABE_ST_IDLE;
                end
            endcase
        end
    end

    // Pending results captured when the operation is taken.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            op_ff <= CABE_OP_NONE;
            res_lo_ff <= `CABE_ALL_ZERO;
            res_hi_ff <= `CABE_ALL_ZERO;
            pend_status_ff <= `CABE_STATUS_REGISTER_RST;
            pend_pc_ff <= `CABE_PC_RST;
            wr_lo_pend_ff <= 1'b0;
            wr_hi_pend_ff <= 1'b0;
            push_pend_ff <= 1'b0;
            push_addr_ff <= `CABE_PC_RST;
        end else if (take) begin
            op_ff <= op_code;
            res_lo_ff <= nxt_res_lo;
            res_hi_ff <= nxt_res_hi;
            pend_status_ff <= nxt_status;
            pend_pc_ff <= nxt_pc;
            wr_lo_pend_ff <= nxt_wr_lo;
            wr_hi_pend_ff <= nxt_wr_hi;
            push_pend_ff <= nxt_push;
            push_addr_ff <= pc_ff + `CABE_PC_ONE;
        end
    end

    // Flags and PC change only on the last cycle of an operation.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status_ff <= `CABE_STATUS_REGISTER_RST;
        end else if (done) begin
            status_ff <= pend_status_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pc_ff <= `CABE_PC_RST;
        end else if (done) begin
            pc_ff <= pend_pc_ff;
        end
    end

    adc_sum_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE1]
        take && op_code == CABE_OP_ADD_CARRY |=> done && wr_lo_en &&
        res_lo_ff == `CABE_DATA_W'($past(rd_val) + $past(rr_val) + $past(c_in)))
        else $error("add with carry result or timing wrong");
    word_add_time_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE2]
        take && op_code == CABE_OP_ADD_IMM_WORD |-> ##1 !done ##1 done && wr_hi_en && wr_lo_en)
        else $error("word add not two cycles");
    word_sub_val_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE3]
        take && op_code == CABE_OP_SUB_IMM_WORD |=> {res_hi_ff, res_lo_ff} ==
        `CABE_WORD_W'({$past(rdh_val), $past(rd_val)} - ($past(imm_val) & `CABE_WIMM_MASK)))
        else $error("word subtract result wrong");
    subc_const_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE6]
        take && op_code == CABE_OP_SUB_CARRY_CONST |=>
        res_lo_ff == `CABE_DATA_W'($past(rd_val) - $past(imm_val) - $past(c_in)))
        else $error("subtract with carry constant wrong");
    clear_bits_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE10]
        take && op_code == CABE_OP_CLEAR_BITS |=> res_lo_ff == ($past(rd_val) & ~$past(imm_val)))
        else $error("clear bits result wrong");
    neg_val_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE9]
        take && op_code == CABE_OP_TWOS_COMPLEMENT |=> res_lo_ff == `CABE_DATA_W'(-$past(rd_val)))
        else $error("two's complement wrong");
    indirect_jump_op_pc_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE13]
        take && op_code == CABE_OP_INDIRECT_JUMP |-> ##3 pc_ff == $past(ptr_val, 3) &&
        status_ff == $past(status_ff, 3))
        else $error("indirect jump PC or flags wrong");
    indirect_call_op_time_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE14]
        take && op_code == CABE_OP_INDIRECT_CALL |-> ##1 !done ##1 !done ##1 done && push_en)
        else $error("indirect call not three cycles");
    cpi_nowrite_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE16]
        take && op_code == CABE_OP_COMPARE_IMMEDIATE |=> done && !wr_lo_en)
        else $error("compare immediate wrote a register");
    skip_eq_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE15]
        take && op_code == CABE_OP_COMPARE_SKIP_EQUAL && rd_val == rr_val && !next_two_word
        |-> ##1 !done ##1 done ##1 pc_ff == $past(pc_ff, 3) + `CABE_PC_TWO)
        else $error("compare skip equal wrong");
    branch_flag_set_pc_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE19]
        take && op_code == CABE_OP_BRANCH_FLAG_SET && cond |-> ##1 !done ##1 done ##1 pc_ff ==
        $past(pc_ff, 3) + `CABE_WORD_W'($signed($past(rel_off, 3))) + `CABE_PC_ONE)
        else $error("taken branch PC wrong");
    keep_s_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE20]
        done && !is_word_op(op_ff) |=> s_flag == $past(s_flag))
        else $error("sign flag changed by byte operation");
endmodule : cabe_execute
`default_nettype wire

// ---- core/cabe_map.svh ----
// Purpose: Named constants for the ALU and branch execute block.
// Assumes: Included by its bare name from the package and the modules.
// Notes: Definitions only.
`ifndef CABE_MAP_SVH
`define CABE_MAP_SVH
`define CABE_DATA_W 8
`define CABE_WORD_W 16
`define CABE_NIB_W 4
`define CABE_REL_W 7
`define CABE_BSEL_W 3
`define CABE_CNT_W 3
`define CABE_WIMM_MASK 8'h3f
`define CABE_ALL_ONES 8'hff
`define CABE_ALL_ZERO 8'h00
`define CABE_STATUS_REGISTER_RST 8'h00
`define CABE_PC_RST 16'h0000
`define CABE_BIT_C 0
`define CABE_BIT_Z 1
`define CABE_BIT_N 2
`define CABE_BIT_V 3
`define CABE_BIT_S 4
`define CABE_BIT_H 5
`define CABE_CYC_ONE 3'h1
`define CABE_CYC_TWO 3'h2
`define CABE_CYC_THREE 3'h3
`define CABE_PC_ONE 16'h0001
`define CABE_PC_TWO 16'h0002
`define CABE_PC_THREE 16'h0003
`endif

// ---- core/cabe_pkg.sv ----
// Purpose: Types shared by the execute block and its helpers.
// Assumes: cabe_map.svh supplies the numeric constants.
// Notes: Operation codes are local to this core.
`include "cabe_map.svh"
package cabe_pkg;
    typedef enum logic [4:0] {
        CABE_OP_NONE = 5'h00,
        CABE_OP_ADD_CARRY = 5'h01,
        CABE_OP_ADD_IMM_WORD = 5'h02,
        CABE_OP_SUB_IMM_WORD = 5'h03,
        CABE_OP_SUB_CONST = 5'h04,
        CABE_OP_SUB_CARRY_REGS = 5'h05,
        CABE_OP_SUB_CARRY_CONST = 5'h06,
        CABE_OP_AND_CONST = 5'h07,
        CABE_OP_OR_CONST = 5'h08,
        CABE_OP_ONES_COMPLEMENT = 5'h09,
        CABE_OP_TWOS_COMPLEMENT = 5'h0a,
        CABE_OP_CLEAR_BITS = 5'h0b,
        CABE_OP_SET_BITS = 5'h0c,
        CABE_OP_TEST_ZERO_MINUS = 5'h0d,
        CABE_OP_INDIRECT_JUMP = 5'h0e,
        CABE_OP_INDIRECT_CALL = 5'h0f,
        CABE_OP_COMPARE_SKIP_EQUAL = 5'h10,
        CABE_OP_COMPARE_IMMEDIATE = 5'h11,
        CABE_OP_SKIP_REG_BIT_CLEAR = 5'h12,
        CABE_OP_SKIP_IO_BIT_SET = 5'h13,
        CABE_OP_BRANCH_FLAG_SET = 5'h14
    } cabe_op_t;
    typedef enum logic {
        CABE_ST_IDLE = 1'b0,
        CABE_ST_EXEC = 1'b1
    } cabe_state_t;
endpackage : cabe_pkg

// ---- core/cabe_addsub.sv ----
// Purpose: Adder and subtractor with carry, half carry and overflow.
// Assumes: W is at least 8; cin is a carry in or, when sub is set, a borrow in.
// Notes: On subtraction carry and half carry report a borrow.
`timescale 1ns/1ps
`default_nettype none
`include "cabe_map.svh"
module cabe_addsub #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [W-1:0] sum,
    output logic cout,
    output logic half,
    output logic ovf
);
    logic [W-1:0] bb;
    logic ci;
    logic [W:0] full;
    logic [`CABE_NIB_W:0] low;

    // Subtraction runs as a + ~b + ~borrow so one carry chain serves both.
    assign bb = sub ? ~b : b;
    assign ci = sub ? ~cin : cin;
    assign full = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, ci};
    assign low = {1'b0, a[`CABE_NIB_W-1:0]} + {1'b0, bb[`CABE_NIB_W-1:0]} + {{`CABE_NIB_W{1'b0}}, ci};
    assign sum = full[W-1:0];
    assign cout = full[W] ^ sub;
    assign half = low[`CABE_NIB_W] ^ sub;
    assign ovf = (a[W-1] == bb[W-1]) && (full[W-1] != a[W-1]);
endmodule : cabe_addsub
`default_nettype wire

// ---- core/cabe_cond.sv ----
// Purpose: Skip and branch condition evaluation.
// Assumes: Operands are stable while the operation is offered.
// Notes: Output is zero for operations that never transfer control.
`timescale 1ns/1ps
`default_nettype none
`include "cabe_map.svh"
module cabe_cond
    import cabe_pkg::*;
(
    input wire cabe_op_t op_code,
    input wire logic [`CABE_DATA_W-1:0] rd_val,
    input wire logic [`CABE_DATA_W-1:0] rr_val,
    input wire logic [`CABE_DATA_W-1:0] io_val,
    input wire logic [`CABE_DATA_W-1:0] status,
    input wire logic [`CABE_BSEL_W-1:0] bit_sel,
    output logic cond
);
    always_comb begin
        case (op_code)
            CABE_OP_COMPARE_SKIP_EQUAL: cond = (rd_val == rr_val); // [RULE15]
            CABE_OP_SKIP_REG_BIT_CLEAR: cond = !rr_val[bit_sel]; // [RULE17]
            CABE_OP_SKIP_IO_BIT_SET: cond = io_val[bit_sel]; // [RULE18]
            CABE_OP_BRANCH_FLAG_SET: cond = status[bit_sel]; // [RULE19]
            default: cond = 1'b0;
        endcase
    end
endmodule : cabe_cond
`default_nettype wire

// ---- dv/test_cpu_alu_branch_execute.sv ----
// Purpose: Self-checking bench for the execute block against a reference model.
// Assumes: Inputs change on the falling edge and are sampled at the take edge.
// Notes: Junk is offered while busy, which the block must ignore.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_alu_branch_execute
    import cabe_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    cabe_op_t op_code = CABE_OP_NONE;
    logic [7:0] rd_val = 8'h00, rdh_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00, io_val = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [6:0] rel_off = 7'h00;
    logic [15:0] ptr_val = 16'h0000;
    logic next_two_word = 1'b0;
    logic op_ready, busy, done, wr_lo_en, wr_hi_en, push_en;
    logic [7:0] res_lo_ff, res_hi_ff, status_ff;
    logic [15:0] pc_ff, push_addr_ff;
    logic [7:0] mdl_st_ff;
    logic [15:0] mdl_pc_ff;
    int n_fail = 0;
    int check_count = 0;

    always #10 core_clk = ~core_clk;

    cabe_execute u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
        .rd_val(rd_val), .rdh_val(rdh_val), .rr_val(rr_val), .imm_val(imm_val), .io_val(io_val),
        .bit_sel(bit_sel), .rel_off(rel_off), .ptr_val(ptr_val), .next_two_word(next_two_word),
        .op_ready(op_ready), .busy(busy), .done(done), .wr_lo_en(wr_lo_en), .wr_hi_en(wr_hi_en),
        .res_lo_ff(res_lo_ff), .res_hi_ff(res_hi_ff), .status_ff(status_ff), .pc_ff(pc_ff),
        .push_en(push_en), .push_addr_ff(push_addr_ff));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic do_reset(input int cycles);
        sys_rst = 1'b1;
        repeat (cycles) @(negedge core_clk);
        chk("status", 16'h0000, {8'h00, status_ff});
        chk("pc", 16'h0000, pc_ff);
        chk("ready", 16'h0001, 16'(op_ready));
        chk("busy", 16'h0000, 16'(busy));
        sys_rst = 1'b0;
        mdl_st_ff = 8'h00;
        mdl_pc_ff = 16'h0000;
    endtask : do_reset

    task automatic run_op(input cabe_op_t op);
        int a, b, ci, kind, sum, n, cyc;
        logic [7:0] res, st;
        logic [15:0] pc, wres;
        logic cnd, wr;
        op_code = op;
        rd_val = 8'($urandom);
        rdh_val = 8'($urandom);
        rr_val = ($urandom % 2) ? rd_val : 8'($urandom);
        imm_val = 8'($urandom);
        io_val = 8'($urandom);
        bit_sel = 3'($urandom);
        rel_off = 7'($urandom);
        ptr_val = 16'($urandom);
        next_two_word = 1'($urandom);
        op_valid = 1'b1;
        st = mdl_st_ff;
        pc = mdl_pc_ff + 16'h0001;
        a = rd_val;
        n = 1;
        res = 8'h00;
        wres = 16'h0000;
        case (op)
            CABE_OP_ADD_CARRY: kind = 1;
            CABE_OP_SUB_CONST, CABE_OP_COMPARE_IMMEDIATE: kind = 2;
            CABE_OP_SUB_CARRY_REGS, CABE_OP_SUB_CARRY_CONST: kind = 2;
            CABE_OP_ONES_COMPLEMENT, CABE_OP_TWOS_COMPLEMENT: kind = 2;
            CABE_OP_AND_CONST, CABE_OP_OR_CONST, CABE_OP_CLEAR_BITS: kind = 3;
            CABE_OP_SET_BITS, CABE_OP_TEST_ZERO_MINUS: kind = 3;
            CABE_OP_ADD_IMM_WORD, CABE_OP_SUB_IMM_WORD: kind = 4;
            default: kind = 0;
        endcase
        b = (op inside {CABE_OP_ADD_CARRY, CABE_OP_SUB_CARRY_REGS}) ? rr_val : imm_val;
        ci = (op inside {CABE_OP_ADD_CARRY, CABE_OP_SUB_CARRY_REGS, CABE_OP_SUB_CARRY_CONST}) ? st[0] : 0;
        if (op inside {CABE_OP_ONES_COMPLEMENT, CABE_OP_TWOS_COMPLEMENT}) begin
            a = (op == CABE_OP_ONES_COMPLEMENT) ? 255 : 0;
            b = rd_val;
        end
        if (kind == 1) begin
            sum = a + b + ci;
            st[5] = (a % 16 + b % 16 + ci) > 15;
            st[0] = sum > 255;
        end else if (kind == 2) begin
            sum = a - b - ci;
            st[5] = (op == CABE_OP_ONES_COMPLEMENT) ? st[5] : ((a % 16 - b % 16 - ci) < 0);
            st[0] = sum < 0;
        end
        res = 8'(sum);
        case (op)
            CABE_OP_AND_CONST: res = rd_val & imm_val;
            CABE_OP_OR_CONST, CABE_OP_SET_BITS: res = rd_val | imm_val;
            CABE_OP_CLEAR_BITS: res = rd_val & (8'hff - imm_val);
            CABE_OP_TEST_ZERO_MINUS: res = rd_val & rd_val;
            default: ;
        endcase
        if (kind inside {[1:3]}) begin
            st[3] = (kind == 3) ? 1'b0 : (((a[7] == b[7]) == (kind == 1)) && (res[7] != a[7]));
            st[1] = res == 8'h00;
            st[2] = res[7];
        end
        if (kind == 4) begin
            a = {rdh_val, rd_val};
            b = imm_val & 8'h3f;
            sum = (op == CABE_OP_ADD_IMM_WORD) ? a + b : a - b;
            wres = 16'(sum);
            st[0] = sum > 65535 || sum < 0;
            st[3] = (op == CABE_OP_ADD_IMM_WORD) ? (!a[15] && wres[15]) : (a[15] && !wres[15]);
            st[1] = wres == 16'h0000;
            st[2] = wres[15];
            st[4] = wres[15] ^ st[3];
            n = 2;
        end
        case (op)
            CABE_OP_COMPARE_SKIP_EQUAL: cnd = rd_val == rr_val;
            CABE_OP_SKIP_REG_BIT_CLEAR: cnd = !rr_val[bit_sel];
            CABE_OP_SKIP_IO_BIT_SET: cnd = io_val[bit_sel];
            default: cnd = 1'b0;
        endcase
        if (cnd) begin
            n = next_two_word ? 3 : 2;
            pc = mdl_pc_ff + 16'(n);
        end
        if (op == CABE_OP_BRANCH_FLAG_SET && st[bit_sel]) begin
            n = 2;
            pc = mdl_pc_ff + {{9{rel_off[6]}}, rel_off} + 16'h0001;
        end
        if (op inside {CABE_OP_INDIRECT_JUMP, CABE_OP_INDIRECT_CALL}) begin
            n = (op == CABE_OP_INDIRECT_CALL) ? 3 : 2;
            pc = ptr_val;
        end
        wr = kind != 0 && op != CABE_OP_COMPARE_IMMEDIATE;
        @(posedge core_clk);
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
            if (!done) begin
                chk("busy", 16'h0001, 16'(busy));
                chk("ready", 16'h0000, 16'(op_ready));
                op_code = cabe_op_t'(5'($urandom_range(20)));
            end
        end while (!done && cyc < 8);
        op_valid = 1'b0;
        chk("cycles", 16'(n), 16'(cyc));
        chk("wr_lo_en", 16'(wr), 16'(wr_lo_en));
        chk("wr_hi_en", 16'(kind == 4), 16'(wr_hi_en));
        chk("push_en", 16'(op == CABE_OP_INDIRECT_CALL), 16'(push_en));
        if (wr) chk("res_lo", {8'h00, (kind == 4) ? wres[7:0] : res}, {8'h00, res_lo_ff});
        if (kind == 4) chk("res_hi", {8'h00, wres[15:8]}, {8'h00, res_hi_ff});
        if (op == CABE_OP_INDIRECT_CALL) chk("push_addr", mdl_pc_ff + 16'h0001, push_addr_ff);
        @(negedge core_clk);
        mdl_st_ff = st;
        mdl_pc_ff = pc;
        chk("status", {8'h00, st}, {8'h00, status_ff});
        chk("pc", pc, pc_ff);
    endtask : run_op

    initial begin
        void'($urandom(32'h793da934));
        do_reset(6);
        for (int i = 0; i < 420; i++) begin
            if (i == 210) begin
                do_reset(2);
            end
            run_op(cabe_op_t'(5'((i < 42) ? i % 21 : $urandom_range(20))));
        end
        final_report();
    end

    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule : test_cpu_alu_branch_execute
`default_nettype wire
